//--- logic/stc_timer.sv
// Sixteen-bit timer with interval, capture and PWM modes.
// Functional notes
// - Three modes chosen in control register: interval, capture, PWM.
// - Count clock is system clock divided by 1024, 256, 64, 8 or 1.
// - An external clock pin may also drive the count.
// - Sixteen-bit up-counter, comparator and reference pair, bytes readable.
// - Reset clears control: interval mode, divide by 1024, interrupts off.
// - Clock select bits 7 to 5 equal to 111 stop the counter.
// - Writing one to control bit 2 clears the counter at any time.
// - Control bit 0 enables the wrap interrupt request.
// - Control bit 1 enables the match or capture interrupt request.
// - Two requests on one level, each with its own vector.
// - Match pending flag stays set until software writes zero to it.
// - Wrap pending clears on service or when software writes zero.
// - Interval match raises match interrupt and restarts counter at zero.
// - Each interval match inverts the shared timer output pin.
// - PWM counter is never cleared by a match and wraps freely.
// - PWM output low while reference at most count, high otherwise.
// - PWM period is 65536 count clock periods.
// - PWM and interval toggle share one output pin.
// - Selected capture pin edge copies counter into reference pair.
// - Capture pin routed only when port3 middle field equals 000.
// - Capture mode raises wrap on each wrap, match on each capture.
// - Control register is read and written at address FA.
`timescale 1ns/100ps
module stc_timer
  import stc_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_RST_N,
  input  wire logic       I_CE,
  input  wire logic [7:0] I_REG_ADDR,
  input  wire logic       I_REG_WR,
  input  wire logic [7:0] I_REG_WDATA,
  input  wire logic       I_WRAP_ACK,
  input  wire logic [2:0] I_PORT3_MID_SEL,
  input  wire logic       I_CAPTURE_PIN,
  input  wire logic       I_EXT_COUNT_CLOCK_PIN,
  output logic      [7:0] O_REG_RDATA,
  output logic            O_TIMER_OUT,
  output logic            O_WRAP_IRQ,
  output logic            O_MATCH_CAPTURE_IRQ,
  output logic      [7:0] O_IRQ_VECTOR
);
  import stc_pkg::*;

  logic [7:0]  ctl_r;
  logic [7:0]  ctl_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] ref_r;
  logic [15:0] ref_nxt;
  logic        wrap_pend_r;
  logic        wrap_pend_nxt;
  logic        match_pend_r;
  logic        match_pend_nxt;
  logic        toggle_r;
  logic        toggle_nxt;
  logic        out_r;
  logic        out_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        wrap_irq_r;
  logic        match_irq_r;
  logic [7:0]  vec_r;
  logic        cap_s1_r;
  logic        cap_s2_r;
  logic        cap_s3_r;
  logic        ctl_wr;
  logic        clr_wr;
  logic        refh_wr;
  logic        refl_wr;
  logic        pnd_wr;
  logic [1:0]  mode;
  logic        mode_ivl;
  logic        mode_pwm;
  logic        mode_cap;
  logic        stopped;
  logic        run;
  logic        at_ref;
  logic        at_max;
  logic        ivl_hit;
  logic        wrap_evt;
  logic        cap_route;
  logic        cap_edge;
  logic        pwm_high;

  stc_tick_if tk ();

  // Prescaler supplies one tick per count clock period.
  stc_prescaler u_prescaler (
    .i_clk     (I_CLK),
    .i_rst_n   (I_RST_N),
    .i_ext_pin (I_EXT_COUNT_CLOCK_PIN),
    .tk        (tk)
  );

  // clock select field steers the prescaler.
  assign tk.ce  = I_CE;
  assign tk.sel = ctl_r[CTL_CLK_HI:CTL_CLK_LO];

  assign ctl_wr  = I_CE & I_REG_WR & (I_REG_ADDR == CTL_ADDR);
  assign refh_wr = I_CE & I_REG_WR & (I_REG_ADDR == REF_HI_ADDR);
  assign refl_wr = I_CE & I_REG_WR & (I_REG_ADDR == REF_LO_ADDR);
  assign pnd_wr  = I_CE & I_REG_WR & (I_REG_ADDR == PND_ADDR);
  assign clr_wr  = ctl_wr & I_REG_WDATA[CTL_CLR_BIT];

  assign mode     = ctl_r[CTL_MODE_HI:CTL_MODE_LO];
  assign mode_ivl = (mode == MODE_IVL);
  assign mode_pwm = (mode == MODE_PWM);
  assign mode_cap = (mode == MODE_CAP_R) | (mode == MODE_CAP_F);
  assign stopped  = (tk.sel == CLK_STOP);
  assign run      = tk.tick & ~stopped;

  assign at_ref   = (cnt_r == ref_r);
  assign at_max   = (cnt_r == CNT_MAX);
  assign ivl_hit  = run & mode_ivl & at_ref;
  // wrap event in PWM and capture.
  assign wrap_evt = run & (mode_pwm | mode_cap) & at_max;

  assign cap_route = (I_PORT3_MID_SEL == P3M_CAPTURE);
  assign cap_edge  = I_CE & mode_cap & cap_route &
                     ((mode == MODE_CAP_R) ? (cap_s2_r & ~cap_s3_r) :
                                             (~cap_s2_r & cap_s3_r));

  // interval clears, PWM wraps freely, clear wins.
  assign cnt_nxt = clr_wr  ? CNT_RESET :
                   ivl_hit ? CNT_RESET :
                   run     ? 16'(cnt_r + 16'h0001) : cnt_r;

  // capture load beats a CPU write to the reference pair.
  assign ref_nxt = cap_edge ? cnt_r :
                   refh_wr  ? {I_REG_WDATA, ref_r[7:0]} :
                   refl_wr  ? {ref_r[15:8], I_REG_WDATA} : ref_r;

  // control register, clear bit never stored.
  assign ctl_nxt = ctl_wr ? {I_REG_WDATA[7:3], 1'b0, I_REG_WDATA[1:0]} :
                            ctl_r;

  // match pending sticky, set wins over software clear.
  assign match_pend_nxt = ivl_hit | cap_edge |
                          (match_pend_r &
                           ~(pnd_wr & ~I_REG_WDATA[PND_MATCH_BIT]));
  // wrap pending cleared by service or software, set wins.
  assign wrap_pend_nxt  = wrap_evt |
                          (wrap_pend_r & ~(I_CE & I_WRAP_ACK) &
                           ~(pnd_wr & ~I_REG_WDATA[PND_WRAP_BIT]));

  assign toggle_nxt = toggle_r ^ ivl_hit;
  // PWM high while reference exceeds count, full 16-bit cycle.
  assign pwm_high   = (ref_r > cnt_r);
  assign out_nxt    = mode_pwm ? pwm_high : toggle_r;

  // byte readback of counter, reference, control and pending.
  assign rdata_nxt =
    (I_REG_ADDR == CTL_ADDR)    ? ctl_r :
    (I_REG_ADDR == CNT_HI_ADDR) ? cnt_r[15:8] :
    (I_REG_ADDR == CNT_LO_ADDR) ? cnt_r[7:0] :
    (I_REG_ADDR == REF_HI_ADDR) ? ref_r[15:8] :
    (I_REG_ADDR == REF_LO_ADDR) ? ref_r[7:0] :
    (I_REG_ADDR == PND_ADDR)    ? {4'h0, match_pend_r, wrap_pend_r, 2'h0} :
                                  8'h00;

  // Capture pin synchroniser; stage one feeds only stage two.
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_s3_r <= 1'b0;
    end else if (I_CE) begin
      cap_s1_r <= I_CAPTURE_PIN;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctl_r        <= CTL_RESET;
      cnt_r        <= CNT_RESET;
      ref_r        <= REF_RESET;
      wrap_pend_r  <= 1'b0;
      match_pend_r <= 1'b0;
      toggle_r     <= 1'b0;
    end else if (I_CE) begin
      ctl_r        <= ctl_nxt;
      cnt_r        <= cnt_nxt;
      ref_r        <= ref_nxt;
      wrap_pend_r  <= wrap_pend_nxt;
      match_pend_r <= match_pend_nxt;
      toggle_r     <= toggle_nxt;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      out_r       <= 1'b0;
      rdata_r     <= 8'h00;
      wrap_irq_r  <= 1'b0;
      match_irq_r <= 1'b0;
      vec_r       <= VEC_MATCH;
    end else if (I_CE) begin
      out_r       <= out_nxt;
      rdata_r     <= rdata_nxt;
      wrap_irq_r  <= wrap_pend_r & ctl_r[CTL_OIE_BIT];
      match_irq_r <= match_pend_r & ctl_r[CTL_MIE_BIT];
      vec_r       <= (match_pend_r & ctl_r[CTL_MIE_BIT]) ? VEC_MATCH :
                     VEC_WRAP;
    end
  end

  assign O_TIMER_OUT         = out_r;
  assign O_REG_RDATA         = rdata_r;
  assign O_WRAP_IRQ          = wrap_irq_r;
  assign O_MATCH_CAPTURE_IRQ = match_irq_r;
  assign O_IRQ_VECTOR        = vec_r;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  // An interval match followed by the restart from zero.
  sequence ivl_match_s;
    I_CE && ivl_hit && !clr_wr;
  endsequence
  sequence restart_s;
    cnt_r == CNT_RESET && match_pend_r;
  endsequence

  interval_restart_a: assert property (ivl_match_s |=> restart_s)
    else $error("interval match did not restart counter");

  toggle_flip_a: assert property (
    ivl_match_s |=> (toggle_r != $past(toggle_r)) ##1
                    (!$past(I_CE) || $past(mode_pwm) ||
                     out_r == $past(toggle_r)))
    else $error("interval match did not invert output");

  stop_hold_a: assert property (
    (I_CE && stopped && !clr_wr) |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  clear_count_a: assert property (clr_wr |=> cnt_r == CNT_RESET)
    else $error("clear write did not zero counter");

  pwm_level_a: assert property (
    (I_CE && mode_pwm) |=> out_r == $past(pwm_high))
    else $error("pwm output level wrong");

  pwm_wrap_a: assert property (
    (I_CE && mode_pwm && run && at_max && !clr_wr) |=>
    (cnt_r == CNT_RESET && wrap_pend_r))
    else $error("pwm counter did not wrap with wrap event");

  capture_load_a: assert property (cap_edge |=> ref_r == $past(cnt_r))
    else $error("capture did not load counter value");

  match_sticky_a: assert property (
    (match_pend_r && !(pnd_wr && !I_REG_WDATA[PND_MATCH_BIT])) |=>
    match_pend_r)
    else $error("match pending cleared without software");

  wrap_gate_a: assert property (
    (I_CE && wrap_pend_r && !ctl_r[CTL_OIE_BIT]) |=> !O_WRAP_IRQ)
    else $error("wrap request raised while disabled");

  match_gate_a: assert property (
    (I_CE && match_pend_r && ctl_r[CTL_MIE_BIT]) |=>
    (O_MATCH_CAPTURE_IRQ && O_IRQ_VECTOR == VEC_MATCH))
    else $error("enabled match pending gave no request");
endmodule

//--- logic/stc_pkg.sv
// Shared constants for the sixteen-bit timer with capture and PWM.
package stc_pkg;
  // Register addresses on the CPU register port.
  localparam logic [7:0] CTL_ADDR    = 8'hFA;
  localparam logic [7:0] CNT_HI_ADDR = 8'hF4;
  localparam logic [7:0] CNT_LO_ADDR = 8'hF5;
  localparam logic [7:0] REF_HI_ADDR = 8'hF6;
  localparam logic [7:0] REF_LO_ADDR = 8'hF7;
  localparam logic [7:0] PND_ADDR    = 8'hF8;
  // Reset values and counter maximum.
  localparam logic [7:0]  CTL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] REF_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  // Field positions of the timer control register.
  localparam int CTL_CLK_HI  = 7;
  localparam int CTL_CLK_LO  = 5;
  localparam int CTL_MODE_HI = 4;
  localparam int CTL_MODE_LO = 3;
  localparam int CTL_CLR_BIT = 2;
  localparam int CTL_MIE_BIT = 1;
  localparam int CTL_OIE_BIT = 0;
  // Field positions of the shared pending register.
  localparam int PND_WRAP_BIT  = 2;
  localparam int PND_MATCH_BIT = 3;
  // Count clock selections.
  localparam logic [2:0] CLK_DIV1024 = 3'h0;
  localparam logic [2:0] CLK_DIV256  = 3'h1;
  localparam logic [2:0] CLK_DIV64   = 3'h2;
  localparam logic [2:0] CLK_DIV8    = 3'h3;
  localparam logic [2:0] CLK_DIV1    = 3'h4;
  localparam logic [2:0] CLK_EXT_R   = 3'h5;
  localparam logic [2:0] CLK_EXT_F   = 3'h6;
  localparam logic [2:0] CLK_STOP    = 3'h7;
  // Divider taps: number of low divider bits that must be all ones.
  localparam logic [3:0] TAP_1024 = 4'hA;
  localparam logic [3:0] TAP_256  = 4'h8;
  localparam logic [3:0] TAP_64   = 4'h6;
  localparam logic [3:0] TAP_8    = 4'h3;
  localparam int         DIV_W    = 10;
  // Operating modes.
  localparam logic [1:0] MODE_IVL   = 2'h0;
  localparam logic [1:0] MODE_CAP_R = 2'h1;
  localparam logic [1:0] MODE_CAP_F = 2'h2;
  localparam logic [1:0] MODE_PWM   = 2'h3;
  // Capture routing field value that selects the capture pin.
  localparam logic [2:0] P3M_CAPTURE = 3'h0;
  // Interrupt vectors on the shared level.
  localparam logic [7:0] VEC_WRAP  = 8'hDA;
  localparam logic [7:0] VEC_MATCH = 8'hD8;
endpackage

//--- logic/stc_tick_if.sv
// Count clock request and tick between timer core and prescaler.
`timescale 1ns/100ps
interface stc_tick_if;
  logic       ce;
  logic [2:0] sel;
  logic       tick;
  modport src (input ce, input sel, output tick);
  modport snk (output ce, output sel, input tick);
endinterface

//--- logic/stc_prescaler.sv
// Prescaler and external count clock selector for the timer.
`timescale 1ns/100ps
module stc_prescaler
  import stc_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ext_pin,
  stc_tick_if.src   tk
);
  logic [DIV_W-1:0] div_r;
  logic             ext_s1_r;
  logic             ext_s2_r;
  logic             ext_s3_r;
  logic             ext_rise;
  logic             ext_fall;

  // True when the lowest n bits of the divider are all ones.
  function automatic logic taps_full(input logic [DIV_W-1:0] v,
                                     input logic [3:0]       n);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < DIV_W; i++) begin
      if (i < int'(n) && !v[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Free running divider and external pin synchroniser.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_r    <= '0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else if (tk.ce) begin
      div_r    <= DIV_W'(div_r + 1'b1);
      ext_s1_r <= i_ext_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Edges of the synchronised external clock.
  assign ext_rise = ext_s2_r & ~ext_s3_r;
  assign ext_fall = ~ext_s2_r & ext_s3_r;

  // divided clock mux, external pin source, stop.
  assign tk.tick = !tk.ce ? 1'b0 :
                   (tk.sel == CLK_DIV1024) ? taps_full(div_r, TAP_1024) :
                   (tk.sel == CLK_DIV256)  ? taps_full(div_r, TAP_256)  :
                   (tk.sel == CLK_DIV64)   ? taps_full(div_r, TAP_64)   :
                   (tk.sel == CLK_DIV8)    ? taps_full(div_r, TAP_8)    :
                   (tk.sel == CLK_DIV1)    ? 1'b1 :
                   (tk.sel == CLK_EXT_R)   ? ext_rise :
                   (tk.sel == CLK_EXT_F)   ? ext_fall : 1'b0;

  // Divide-by-one ticks on every enabled cycle.
  div1_tick_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (tk.ce && tk.sel == CLK_DIV1) |-> tk.tick)
    else $error("divide by one did not tick");

  // Stopped selection never ticks.
  stop_tick_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (tk.sel == CLK_STOP) |-> !tk.tick)
    else $error("stopped selection produced a tick");
endmodule

//--- bench/stc_pin_model.sv
// Capture source and external count clock that face the timer pins.
`timescale 1ns/100ps
module stc_pin_model (
  input  wire logic i_clk,
  input  wire logic i_load,
  output logic      o_cap,
  output logic      o_ext
);
  logic load_seen;
  int   gap;
  int   period;

  // Both pins idle low between commanded activity.
  initial begin
    o_cap = 1'b0;
    o_ext = 1'b0;
  end

  // The output pin load counts whole cycles between its falling edges.
  always @(negedge i_clk) begin
    load_seen <= i_load;
    if (load_seen && !i_load) begin
      gap    <= 1;
      period <= gap;
    end else begin
      gap <= gap + 1;
    end
  end

  // Waits whole cycles so every level outlasts the input synchronisers.
  task automatic hold(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic pulse_cap;
    hold(1);
    o_cap = 1'b1;
    hold(4);
    o_cap = 1'b0;
    hold(4);
  endtask

  task automatic ext_edges(input int n);
    repeat (n) begin
      o_ext = 1'b1;
      hold(4);
      o_ext = 1'b0;
      hold(4);
    end
  endtask
endmodule

//--- bench/stc_timer_test.sv
// Self-checking register-level bench for the sixteen-bit timer.
`timescale 1ns/100ps
module stc_timer_test;
  import stc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        ce;
  logic        wr;
  logic        ack;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [7:0]  vec;
  logic [7:0]  rd;
  logic [2:0]  p3m;
  logic        cap;
  logic        ext;
  logic        tout;
  logic        t0;
  logic        wirq;
  logic        mirq;
  logic [15:0] cnt;
  logic [15:0] cnt2;
  logic [15:0] e;
  int          mismatches;
  int          n_checks;
  int          cycles;
  logic [2:0]  sels [5] = '{CLK_DIV1024, CLK_DIV256, CLK_DIV64, CLK_DIV8,
                            CLK_DIV1};
  int          shs [5] = '{10, 8, 6, 3, 0};

  stc_timer dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
    .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
    .I_WRAP_ACK(ack), .I_PORT3_MID_SEL(p3m), .I_CAPTURE_PIN(cap),
    .I_EXT_COUNT_CLOCK_PIN(ext), .O_REG_RDATA(rdata), .O_TIMER_OUT(tout),
    .O_WRAP_IRQ(wirq), .O_MATCH_CAPTURE_IRQ(mirq), .O_IRQ_VECTOR(vec));
  stc_pin_model pm (.i_clk(clk), .i_load(tout), .o_cap(cap), .o_ext(ext));

  // The 40 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cuts a hang short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      test_done();
    end
  end

  // Compares one value and reports a difference at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One register write, strobe held for exactly one edge.
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Read data appears one edge after the address is driven.
  task automatic rreg(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    @(posedge clk);
    #1 rd = rdata;
  endtask

  task automatic rcnt;
    rreg(CNT_HI_ADDR);
    cnt[15:8] = rd;
    rreg(CNT_LO_ADDR);
    cnt[7:0] = rd;
  endtask

  task automatic test_done;
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence of register-level tests.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    ack = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    p3m = 3'h1;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    cyc(16);
    rst_n = 1'b1;
    rreg(CTL_ADDR);
    check(rd, 8'h00);
    rreg(8'h10);
    check(rd, 8'h00);
    wreg(CTL_ADDR, 8'hE4);
    rreg(CTL_ADDR);
    check(rd, 8'hE0);
    rcnt();
    check(cnt, 16'h0000);
    wreg(REF_HI_ADDR, 8'h12);
    wreg(REF_LO_ADDR, 8'h34);
    rreg(REF_HI_ADDR);
    check(rd, 8'h12);
    rreg(REF_LO_ADDR);
    check(rd, 8'h34);
    // Each divider counts about 1024 system cycles, within one tick.
    foreach (sels[i]) begin
      wreg(CTL_ADDR, {sels[i], 5'h04});
      cyc(1022);
      wreg(CTL_ADDR, 8'hE0);
      rcnt();
      e = 16'h0400 >> shs[i];
      check(cnt + 16'h0001 >= e && cnt <= e + 16'h0001, 1'b1);
    end
    cyc(40);
    rcnt();
    cnt2 = cnt;
    cyc(40);
    rcnt();
    check(cnt, cnt2);
    // External pin rising edges are the count ticks.
    wreg(CTL_ADDR, {CLK_EXT_R, 5'h04});
    pm.ext_edges(5);
    wreg(CTL_ADDR, 8'hE0);
    rcnt();
    check(cnt, 16'h0005);
    // Capture with the counter stopped at five, routed and unrouted.
    wreg(PND_ADDR, 8'h00);
    wreg(CTL_ADDR, 8'hEA);
    pm.pulse_cap();
    rreg(REF_LO_ADDR);
    check(rd, 8'h34);
    @(negedge clk);
    p3m = 3'h0;
    pm.pulse_cap();
    rreg(REF_HI_ADDR);
    check(rd, 8'h00);
    rreg(REF_LO_ADDR);
    check(rd, 8'h05);
    wreg(PND_ADDR, 8'hFF);
    rreg(PND_ADDR);
    check(rd, 8'h08);
    check(mirq, 1'b1);
    check(vec, VEC_MATCH);
    wreg(PND_ADDR, 8'h00);
    rreg(PND_ADDR);
    check(rd, 8'h00);
    // A frozen block ignores a capture pulse on the routed pin.
    @(negedge clk);
    ce = 1'b0;
    pm.pulse_cap();
    ce = 1'b1;
    rreg(PND_ADDR);
    check(rd, 8'h00);
    wreg(CTL_ADDR, 8'hE4);
    rcnt();
    check(cnt, 16'h0000);
    // Interval mode at full rate toggles the pin every third tick.
    wreg(REF_LO_ADDR, 8'h02);
    wreg(CTL_ADDR, 8'h86);
    cyc(10);
    t0 = tout;
    cyc(3);
    check(tout, !t0);
    cyc(3);
    check(tout, t0);
    rreg(PND_ADDR);
    check(rd, 8'h08);
    wreg(CTL_ADDR, 8'hE0);
    wreg(PND_ADDR, 8'h00);
    cyc(2);
    check(mirq, 1'b0);
    // PWM with a small reference, then one full wrap.
    wreg(REF_LO_ADDR, 8'h10);
    wreg(CTL_ADDR, 8'h9D);
    cyc(4);
    check(tout, 1'b1);
    cyc(40);
    check(tout, 1'b0);
    rcnt();
    check(cnt > 16'h0010, 1'b1);
    cyc(65500);
    rreg(PND_ADDR);
    check(rd, 8'h04);
    check(wirq, 1'b1);
    check(vec, VEC_WRAP);
    @(negedge clk);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    rreg(PND_ADDR);
    check(rd, 8'h00);
    cyc(2);
    check(wirq, 1'b0);
    cyc(4);
    check(pm.period == 65536, 1'b1);
    test_done();
  end
endmodule
